/* det_model.sv */
// Detector model driving start and stop pulses
`timescale 1ns/1ps
module det_model (
  input wire logic clk,
  output logic start_in,
  output logic [4:0] stop_inputs,
  output logic [15:0] tag_in
);
  // ----
  // Pulses
  // ----
  initial begin
    start_in = 1'b0;
    stop_inputs = 5'h00;
    tag_in = 16'h0000;
  end
  // One start per sweep; line drops so the next edge is seen
  task automatic start_pulse();
    @(posedge clk);
    start_in <= 1'b1;
    @(posedge clk);
    start_in <= 1'b0;
  endtask
  // Tags only count at the stop edge, so they flip afterwards
  task automatic stop_pulse(input logic [4:0] m, input logic [15:0] t);
    @(posedge clk);
    stop_inputs <= m;
    tag_in <= t;
    @(posedge clk);
    stop_inputs <= 5'h00;
    tag_in <= ~t;
  endtask
  task automatic stops_level(input logic [4:0] m);
    @(posedge clk);
    stop_inputs <= m;
  endtask
endmodule // det_model

/* tb.sv */
// Self-checking bench for the sweep timing control
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb
  import tdc_sweep_pkg::*;
;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, fs, ss, acq, err;
  logic [31:0] last_off;
  logic [15:0] last_row;
  logic run, win, pau, blk, start_in, fs_d;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [4:0] stops;
  logic [15:0] tags;
  logic [5:0] taps;
  evt_t evt;
  int err_count, total_checks, cyc, per, rise, n_zero, n_stop;
  int cnt[4], base[4];
  int exp_cnt[4] = '{4, 2, 2, 20};

  tdc_sweep_timing_control tdc_sweep_timing_control_i (.clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .start_in, .stop_inputs(stops),
    .tag_in(tags), .freq_taps(taps), .fast_sync_output(fs), .slow_sync_output(ss),
    .sweep_running(run), .measure_window(win), .trigger_pause_window(pau),
    .end_of_sweep_blank(blk), .acq_running(acq), .evt);
  det_model det_model_i (.clk, .start_in, .stop_inputs(stops), .tag_in(tags));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----
  // Monitors: level lengths, tick period, events, timeout
  // ----
  always @(posedge clk) begin
    cyc <= cyc + 1;
    fs_d <= fs;
    cnt <= '{cnt[0] + int'(run), cnt[1] + int'(win), cnt[2] + int'(blk), cnt[3] + int'(pau)};
    if (fs && !fs_d) begin
      per <= cyc - rise;
      rise <= cyc;
    end
    if (evt.valid && evt.channel == 3'h0 && evt.offset == 32'h0) n_zero <= n_zero + 1;
    if (evt.valid && evt.channel == 3'h2) begin
      n_stop <= n_stop + 1;
      last_off <= evt.offset;
      last_row <= evt.row;
    end
  end
  always @(posedge clk) begin
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  // ----
  // Tasks
  // ----
  // Setup edge, access edge, then hold until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  initial begin
    reset_n = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    taps = 6'h15;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0, r)
    apb(1'b0, 8'h3C, 32'h0);
    `CHK("unmapped", 1'b1, err)
    // Stop 1 on fast, stop 2 inverted on slow
    apb(1'b1, OFS_SYNC, 32'h0000_4201);
    det_model_i.stops_level(5'h03);
    repeat (3) @(posedge clk);
    `CHK("sync stop", 1'b1, fs)
    `CHK("sync inv", 1'b0, ss)
    det_model_i.stops_level(5'h00);
    // Slow output refuses the three fast taps
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFS_SYNC, {18'h0, 6'(SRC_FREQ + i), 2'h0, 6'(SRC_FREQ + i)});
      repeat (3) @(posedge clk);
      `CHK("fast freq", taps[i], fs)
      `CHK("slow freq", (i < 3) & taps[i], ss)
    end
    // Sweep mode: delay 2, sweep 4, blank 2, hold 20
    apb(1'b1, OFS_RANGE, 32'h2);
    apb(1'b1, OFS_ACQ_DELAY, 32'h2);
    apb(1'b1, OFS_EOS_DEAD, 32'h2);
    apb(1'b1, OFS_HOLD_AFTER, 32'd20);
    apb(1'b1, OFS_SYNC, {26'h0, SRC_SWEEP});
    apb(1'b1, OFS_CTRL, 32'h1);
    base = cnt;
    det_model_i.start_pulse();
    repeat (40) @(posedge clk);
    for (int i = 0; i < 4; i++) `CHK("len", exp_cnt[i], cnt[i] - base[i])
    apb(1'b0, OFS_SWEEP_COUNT, 32'h0);
    `CHK("sweeps", 32'h1, r)
    `CHK("sweep bit", 1'b1, fs)
    // Second start lands inside the hold time
    det_model_i.start_pulse();
    repeat (10) @(posedge clk);
    det_model_i.start_pulse();
    repeat (40) @(posedge clk);
    apb(1'b0, OFS_SWEEP_COUNT, 32'h0);
    `CHK("held start", 32'h2, r)
    `CHK("sweep bit", 1'b0, fs)
    // One-sweep preset with start events and a stop in the window
    apb(1'b1, OFS_RANGE, 32'h4);
    apb(1'b1, OFS_SWEEP_PRESET, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h61);
    det_model_i.start_pulse();
    repeat (4) @(posedge clk);
    det_model_i.stop_pulse(5'h02, 16'h0001);
    repeat (60) @(posedge clk);
    `CHK("start evt", 1, n_zero)
    `CHK("stop evt", 1, n_stop)
    `CHK("preset", 1'b0, acq)
    // Time differences, 8 bins, two one-hot tags; stops two cycles apart
    apb(1'b1, OFS_RANGE, 32'h0002_0003);
    apb(1'b1, OFS_CTRL, 32'h851);
    det_model_i.start_pulse();
    @(posedge clk);
    det_model_i.stop_pulse(5'h02, 16'h0001);
    det_model_i.stop_pulse(5'h02, 16'h0003);
    repeat (40) @(posedge clk);
    `CHK("diff evts", 3, n_stop)
    `CHK("diff offset", 32'h2, last_off)
    `CHK("tag row", 16'h3, last_row)
    // Endless run begun by software, time bit 0 on fast output
    apb(1'b1, OFS_SYNC, {26'h0, SRC_TIME});
    apb(1'b1, OFS_CTRL, 32'hD);
    repeat (600) @(posedge clk);
    `CHK("endless", 1'b1, run)
    `CHK("tick", 128, per)
    apb(1'b1, OFS_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    `CHK("stopped", 1'b0, acq)
    end_sim();
  end
endmodule // tb

/* tdc_sweep_pkg.sv */
// Shared constants, register map and carrier types for the sweep timing control
package tdc_sweep_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SYNC = 8'h04;
  localparam logic [7:0] OFS_SWEEP_PRESET = 8'h08;
  localparam logic [7:0] OFS_START_PRESET = 8'h0C;
  localparam logic [7:0] OFS_TIME_PRESET = 8'h10;
  localparam logic [7:0] OFS_ACQ_DELAY = 8'h14;
  localparam logic [7:0] OFS_HOLD_AFTER = 8'h18;
  localparam logic [7:0] OFS_EOS_DEAD = 8'h1C;
  localparam logic [7:0] OFS_RANGE = 8'h20;
  localparam logic [7:0] OFS_CYCLES = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_SWEEP_COUNT = 8'h2C;
  localparam logic [7:0] OFS_TIME_LO = 8'h30;
  localparam logic [7:0] OFS_TIME_HI = 8'h34;
  localparam logic [7:0] OFS_START_COUNT = 8'h38;

  // ----------------------------------------------------------------
  // Control register bits (bits 0 and 1 are write-only strobes)
  // ----------------------------------------------------------------
  localparam int CTRL_BEGIN_ACQ = 0;
  localparam int CTRL_STOP_ACQ = 1;
  localparam int CTRL_ENDLESS = 2;
  localparam int CTRL_SOFT_BEGIN = 3;
  localparam int CTRL_TIME_DIFF = 4;
  localparam int CTRL_START_EVT = 5;
  localparam int CTRL_SWEEP_PRE = 6;
  localparam int CTRL_START_PRE = 7;
  localparam int CTRL_TIME_PRE = 8;
  localparam int CTRL_SEQ = 9;
  localparam int CTRL_TAG_BINARY = 10;
  localparam int CTRL_TAG_EN = 11;
  localparam int CTRL_W = 12;
  localparam logic [11:0] CTRL_STORE_MASK = 12'hFFC;

  // ----------------------------------------------------------------
  // Field positions and limits
  // ----------------------------------------------------------------
  localparam int SYNC2_LSB = 8;
  localparam int SEL_W = 6;
  localparam int RANGE_BIN_LSB = 8;
  localparam int RANGE_TAG_LSB = 16;
  localparam logic [4:0] BIN_SHIFT_MAX = 5'h18;
  localparam logic [4:0] TAG_COUNT_MAX = 5'h10;
  localparam int TIME_W = 54;
  localparam int SWEEP_TIME_W = 48;
  localparam int TAG_W = 16;
  localparam int STOP_N = 5;
  localparam int FREQ_N = 6;

  // ----------------------------------------------------------------
  // Sync source codes
  // ----------------------------------------------------------------
  localparam logic [5:0] SRC_START = 6'h00;
  localparam logic [5:0] SRC_STATUS = 6'h06;
  localparam logic [5:0] SRC_FREQ = 6'h0A;
  localparam logic [5:0] SRC_FREQ_FAST = 6'h0D;
  localparam logic [5:0] SRC_FREQ_END = 6'h0F;
  localparam logic [5:0] SRC_TIME = 6'h10;
  localparam logic [5:0] SRC_SWEEP = 6'h30;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam logic [5:0] TICK_LAST = 6'h3F;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_WAIT = 3'b001,
    PH_DELAY = 3'b010,
    PH_SWEEP = 3'b011,
    PH_EOS = 3'b100,
    PH_HOLD = 3'b101
  } phase_t;

  typedef struct packed {
    logic valid;
    logic [2:0] channel;
    logic [31:0] offset;
    logic [53:0] stamp;
    logic [15:0] row;
    logic [15:0] part;
  } evt_t;

endpackage

/* tdc_sweep_properties.sv */
// Port-level checker for the sweep timing control
`timescale 1ns/1ps
module tdc_sweep_properties
  import tdc_sweep_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sweep_running,
  input wire logic measure_window,
  input wire logic trigger_pause_window,
  input wire logic end_of_sweep_blank,
  input wire logic acq_running,
  input wire evt_t evt
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Register bus
  // ----
  // Answer comes one cycle after the access is taken
  ready_time_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  ready_pulse_a: assert property (pready |-> $past(penable) ##1 !pready)
    else $error("ready not a pulse");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // ----
  // Status levels and events
  // ----
  window_run_a:
    assert property (measure_window |-> sweep_running) else $error("window outside run");
  blank_alone_a:
    assert property (end_of_sweep_blank |-> !sweep_running && !trigger_pause_window)
      else $error("blank overlaps");
  pause_idle_a:
    assert property (trigger_pause_window |-> !sweep_running && !measure_window)
      else $error("sweep in hold");
  run_acq_a:
    assert property (sweep_running |-> acq_running || $past(acq_running))
      else $error("run without acquisition");
  // Registered levels may lag, so two cycles back are allowed
  stop_window_a:
    assert property (evt.valid && evt.channel != 3'h0 |-> sweep_running
      || $past(sweep_running) || $past(sweep_running, 2)) else $error("stop outside sweep");
  start_zero_a:
    assert property (evt.valid && evt.channel == 3'h0 |-> evt.offset == 32'h0)
      else $error("start not zero");
endmodule // tdc_sweep_properties

bind tdc_sweep_timing_control tdc_sweep_properties tdc_sweep_properties_i (.clk, .reset_n,
  .psel, .penable, .pready, .pslverr, .sweep_running, .measure_window,
  .trigger_pause_window, .end_of_sweep_blank, .acq_running, .evt);

/* tdc_sweep_timing_control.sv */
// Sweep and timing control with APB register access and sync output routing
//
// Operation
// - Each sync output selects input or internal source
// - Six fixed square-wave frequencies available on sync
// - Three fastest frequencies only on fast sync
// - Running, window and hold-off status signals
// - Blank signal during end-of-sweep dead time
// - Any time counter bit 0..31 on sync
// - Any sweep counter bit 0..11 on sync
// - Time counter ticks every 64 dwell periods
// - Per-output invert of sync level
// - Sweep mode: start pulse begins each sweep
// - Endless mode: one sweep runs until stopped
// - Endless: full time kept, channel pointer wraps
// - Software begin needs no external start pulse
// - Time difference: offsets from first stop
// - Out-of-range stop becomes new reference
// - Start events inserted as zero events
// - Sweep, start and time presets stop acquisition
// - Sequential cycles and repeated sequences on preset
// - Tag rows: one-hot n+2 or binary pattern
// - Bin width powers of two only
// - Ignore events until acquisition delay elapsed
// - No new sweep until hold time elapsed
//
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module tdc_sweep_timing_control
  import tdc_sweep_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_in,
  input wire logic [4:0] stop_inputs,
  input wire logic [15:0] tag_in,
  input wire logic [5:0] freq_taps,
  output logic fast_sync_output,
  output logic slow_sync_output,
  output logic sweep_running,
  output logic measure_window,
  output logic trigger_pause_window,
  output logic end_of_sweep_blank,
  output logic acq_running,
  output evt_t evt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] ctrl;
    logic [15:0] sync_cfg;
    logic [31:0] sweep_preset;
    logic [31:0] start_preset;
    logic [31:0] time_preset;
    logic [31:0] acq_delay;
    logic [31:0] hold_after;
    logic [31:0] eos_dead;
    logic [4:0] range_log2;
    logic [4:0] bin_shift;
    logic [4:0] tag_count;
    logic [15:0] cycles;
    logic [15:0] sequences;
    phase_t phase;
    logic acquiring;
    logic [5:0] prescale;
    logic [53:0] time_cnt;
    logic [31:0] elapsed;
    logic [31:0] sweep_cnt;
    logic [31:0] start_cnt;
    logic [31:0] phase_cnt;
    logic [47:0] sweep_time;
    logic [15:0] cycle_idx;
    logic [15:0] seq_idx;
    logic ref_valid;
    logic [47:0] ref_time;
    logic [4:0] stop_prev;
    logic start_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic fast_sync;
    logic slow_sync;
    logic running;
    logic window;
    logic pause;
    logic blank;
    evt_t evt;
  } state_t;

  state_t s;
  state_t next_s;

  // One-hot tag row: no tag, single tag index + 1, or the overflow row
  function automatic logic [15:0] tag_row(input logic [15:0] tags, input logic [4:0] n,
                                          input logic binary);
    logic [4:0] ones;
    logic [15:0] idx;
    ones = 5'h00;
    idx = 16'h0000;
    for (int i = 0; i < TAG_W; i++) begin
      if (tags[i]) begin
        ones = ones + 5'h01;
        idx = 16'(i + 1);
      end
    end
    if (binary) begin
      tag_row = tags;
    end else if (ones == 5'h00) begin
      tag_row = 16'h0000;
    end else if (ones == 5'h01) begin
      tag_row = idx;
    end else begin
      tag_row = 16'(n) + 16'h0001;
    end
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic start_edge;
    logic [4:0] stop_edge;
    logic apb_wr;
    logic apb_rd;
    logic begin_sweep;
    logic sweep_end;
    logic preset_hit;
    logic restart;
    logic stop_hit;
    logic [2:0] stop_ch;
    logic [5:0] shift;
    logic [63:0] len_probe;
    logic [47:0] ptr_abs;
    logic [47:0] ptr_mask;
    logic [47:0] diff;
    logic [15:0] tag_mask;
    logic [63:0] src;
    logic [5:0] sel1;
    logic [5:0] sel2;
    start_edge = 1'b0;
    stop_edge = 5'h00;
    apb_wr = 1'b0;
    apb_rd = 1'b0;
    begin_sweep = 1'b0;
    sweep_end = 1'b0;
    preset_hit = 1'b0;
    restart = 1'b0;
    stop_hit = 1'b0;
    stop_ch = 3'h0;
    shift = 6'h00;
    len_probe = 64'h0;
    ptr_abs = 48'h0;
    ptr_mask = 48'h0;
    diff = 48'h0;
    tag_mask = 16'h0000;
    src = 64'h0;
    sel1 = 6'h00;
    sel2 = 6'h00;
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.evt.valid = 1'b0;

    // Inputs are synchronous; events are rising edges
    start_edge = start_in & ~s.start_prev;
    stop_edge = stop_inputs & ~s.stop_prev;
    next_s.start_prev = start_in;
    next_s.stop_prev = stop_inputs;
    apb_wr = psel & penable & pwrite & ~s.pready;
    apb_rd = psel & penable & ~pwrite & ~s.pready;

    // Channel pointer: dwell time scaled by a power-of-two bin, masked to range
    shift = 6'(s.range_log2) + 6'(s.bin_shift);
    len_probe = 64'(s.sweep_time + 48'h1) >> shift;
    ptr_abs = s.sweep_time >> s.bin_shift;
    ptr_mask = (48'h1 << s.range_log2) - 48'h1;

    // Time counter advances once per 64 dwell periods
    if (s.acquiring) begin
      next_s.prescale = s.prescale + 6'h01;
      if (s.prescale == TICK_LAST) begin
        next_s.time_cnt = s.time_cnt + 54'h1;
        next_s.elapsed = s.elapsed + 32'h1;
      end
      if (start_edge) begin
        next_s.start_cnt = s.start_cnt + 32'h1;
      end
    end

    // Sweep sequencing
    case (s.phase)
      PH_IDLE: begin
        next_s.phase = PH_IDLE;
      end
      PH_WAIT: begin
        // Soft begin and endless both launch without an external pulse
        if (start_edge || s.ctrl[CTRL_SOFT_BEGIN] || s.ctrl[CTRL_ENDLESS]) begin
          begin_sweep = 1'b1;
        end
      end
      PH_DELAY: begin
        next_s.sweep_time = s.sweep_time + 48'h1;
        next_s.phase_cnt = s.phase_cnt + 32'h1;
        if (s.phase_cnt + 32'h1 >= s.acq_delay) begin
          next_s.phase = PH_SWEEP;
        end
      end
      PH_SWEEP: begin
        next_s.sweep_time = s.sweep_time + 48'h1;
        // Endless sweeps never end; the pointer simply wraps
        if (!s.ctrl[CTRL_ENDLESS] && len_probe != 64'h0) begin
          sweep_end = 1'b1;
        end
      end
      PH_EOS: begin
        next_s.phase_cnt = s.phase_cnt + 32'h1;
        if (s.phase_cnt + 32'h1 >= s.eos_dead) begin
          next_s.phase_cnt = 32'h0;
          next_s.phase = (s.hold_after != 32'h0) ? PH_HOLD : PH_WAIT;
        end
      end
      PH_HOLD: begin
        // Starts arriving here are counted but do not launch a sweep
        next_s.phase_cnt = s.phase_cnt + 32'h1;
        if (s.phase_cnt + 32'h1 >= s.hold_after) begin
          next_s.phase = PH_WAIT;
        end
      end
      default: begin
        next_s.phase = PH_IDLE;
      end
    endcase

    if (begin_sweep) begin
      next_s.sweep_cnt = s.sweep_cnt + 32'h1;
      next_s.sweep_time = 48'h0;
      next_s.phase_cnt = 32'h0;
      next_s.ref_valid = 1'b0;
      next_s.phase = (s.acq_delay != 32'h0) ? PH_DELAY : PH_SWEEP;
      if (s.ctrl[CTRL_START_EVT]) begin
        next_s.evt.valid = 1'b1;
        next_s.evt.channel = 3'h0;
        next_s.evt.offset = 32'h0;
        next_s.evt.stamp = s.time_cnt;
        next_s.evt.row = 16'h0000;
        next_s.evt.part = s.cycle_idx;
      end
    end

    if (sweep_end) begin
      next_s.phase_cnt = 32'h0;
      if (s.eos_dead != 32'h0) begin
        next_s.phase = PH_EOS;
      end else if (s.hold_after != 32'h0) begin
        next_s.phase = PH_HOLD;
      end else begin
        next_s.phase = PH_WAIT;
      end
    end

    // Stop events, only inside the measurement window; lowest input wins a tie
    for (int i = STOP_N - 1; i >= 0; i--) begin
      if (stop_edge[i]) begin
        stop_hit = 1'b1;
        stop_ch = 3'(i + 1);
      end
    end
    if (stop_hit && s.phase == PH_SWEEP) begin
      tag_mask = 16'((17'h1 << s.tag_count) - 17'h1);
      next_s.evt.valid = 1'b1;
      next_s.evt.channel = stop_ch;
      next_s.evt.stamp = s.time_cnt;
      next_s.evt.part = s.cycle_idx;
      next_s.evt.row = s.ctrl[CTRL_TAG_EN] ?
        tag_row(tag_in & tag_mask, s.tag_count, s.ctrl[CTRL_TAG_BINARY]) : 16'h0000;
      next_s.evt.offset = 32'(ptr_abs & ptr_mask);
      if (s.ctrl[CTRL_TIME_DIFF]) begin
        diff = ptr_abs - s.ref_time;
        if (!s.ref_valid || (diff >> s.range_log2) != 48'h0) begin
          next_s.ref_valid = 1'b1;
          next_s.ref_time = ptr_abs;
          next_s.evt.offset = 32'h0;
        end else begin
          next_s.evt.offset = 32'(diff);
        end
      end
    end

    // Presets; sweep and start counts are judged when a sweep finishes
    if (s.acquiring) begin
      if (s.ctrl[CTRL_TIME_PRE] && s.elapsed >= s.time_preset) begin
        preset_hit = 1'b1;
      end
      if (sweep_end && s.ctrl[CTRL_SWEEP_PRE] && s.sweep_cnt >= s.sweep_preset) begin
        preset_hit = 1'b1;
      end
      if (sweep_end && s.ctrl[CTRL_START_PRE] && s.start_cnt >= s.start_preset) begin
        preset_hit = 1'b1;
      end
    end
    if (preset_hit) begin
      if (s.ctrl[CTRL_SEQ] && s.cycle_idx + 16'h1 < s.cycles) begin
        next_s.cycle_idx = s.cycle_idx + 16'h1;
        restart = 1'b1;
      end else if (s.ctrl[CTRL_SEQ] && s.seq_idx + 16'h1 < s.sequences) begin
        next_s.seq_idx = s.seq_idx + 16'h1;
        next_s.cycle_idx = 16'h0;
        restart = 1'b1;
      end else begin
        next_s.acquiring = 1'b0;
        next_s.phase = PH_IDLE;
      end
    end

    // APB register writes; a begin strobe overrides sequencing this cycle
    if (apb_wr) begin
      next_s.pready = 1'b1;
      if (paddr == OFS_CTRL) begin
        next_s.ctrl = pwdata[CTRL_W-1:0] & CTRL_STORE_MASK;
        if (pwdata[CTRL_BEGIN_ACQ]) begin
          next_s.acquiring = 1'b1;
          next_s.cycle_idx = 16'h0;
          next_s.seq_idx = 16'h0;
          restart = 1'b1;
        end else if (pwdata[CTRL_STOP_ACQ]) begin
          next_s.acquiring = 1'b0;
          next_s.phase = PH_IDLE;
        end
      end else if (paddr == OFS_SYNC) begin
        next_s.sync_cfg = pwdata[15:0];
      end else if (paddr == OFS_SWEEP_PRESET) begin
        next_s.sweep_preset = pwdata;
      end else if (paddr == OFS_START_PRESET) begin
        next_s.start_preset = pwdata;
      end else if (paddr == OFS_TIME_PRESET) begin
        next_s.time_preset = pwdata;
      end else if (paddr == OFS_ACQ_DELAY) begin
        next_s.acq_delay = pwdata;
      end else if (paddr == OFS_HOLD_AFTER) begin
        next_s.hold_after = pwdata;
      end else if (paddr == OFS_EOS_DEAD) begin
        next_s.eos_dead = pwdata;
      end else if (paddr == OFS_RANGE) begin
        next_s.range_log2 = pwdata[4:0];
        // Exponent form keeps every bin width a power of two
        next_s.bin_shift = (pwdata[RANGE_BIN_LSB+:5] > BIN_SHIFT_MAX) ?
          BIN_SHIFT_MAX : pwdata[RANGE_BIN_LSB+:5];
        next_s.tag_count = (pwdata[RANGE_TAG_LSB+:5] > TAG_COUNT_MAX) ?
          TAG_COUNT_MAX : pwdata[RANGE_TAG_LSB+:5];
      end else if (paddr == OFS_CYCLES) begin
        next_s.cycles = pwdata[15:0];
        next_s.sequences = pwdata[31:16];
      end else if (paddr == OFS_STATUS || paddr == OFS_SWEEP_COUNT || paddr == OFS_TIME_LO ||
                   paddr == OFS_TIME_HI || paddr == OFS_START_COUNT) begin
        next_s.pslverr = 1'b0;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // Fresh acquisition or next cycle: counters cleared, wait for a start
    if (restart) begin
      next_s.phase = PH_WAIT;
      next_s.sweep_cnt = 32'h0;
      next_s.start_cnt = 32'h0;
      next_s.elapsed = 32'h0;
      next_s.time_cnt = 54'h0;
      next_s.prescale = 6'h00;
      next_s.sweep_time = 48'h0;
      next_s.phase_cnt = 32'h0;
      next_s.ref_valid = 1'b0;
    end

    // APB reads
    if (apb_rd) begin
      next_s.pready = 1'b1;
      next_s.prdata = 32'h0;
      if (paddr == OFS_CTRL) begin
        next_s.prdata = {20'h0, s.ctrl};
      end else if (paddr == OFS_SYNC) begin
        next_s.prdata = {16'h0, s.sync_cfg};
      end else if (paddr == OFS_SWEEP_PRESET) begin
        next_s.prdata = s.sweep_preset;
      end else if (paddr == OFS_START_PRESET) begin
        next_s.prdata = s.start_preset;
      end else if (paddr == OFS_TIME_PRESET) begin
        next_s.prdata = s.time_preset;
      end else if (paddr == OFS_ACQ_DELAY) begin
        next_s.prdata = s.acq_delay;
      end else if (paddr == OFS_HOLD_AFTER) begin
        next_s.prdata = s.hold_after;
      end else if (paddr == OFS_EOS_DEAD) begin
        next_s.prdata = s.eos_dead;
      end else if (paddr == OFS_RANGE) begin
        next_s.prdata = {11'h0, s.tag_count, 3'h0, s.bin_shift, 3'h0, s.range_log2};
      end else if (paddr == OFS_CYCLES) begin
        next_s.prdata = {s.sequences, s.cycles};
      end else if (paddr == OFS_STATUS) begin
        next_s.prdata = {s.seq_idx[7:0], s.cycle_idx[7:0], 12'h0, s.acquiring, s.phase};
      end else if (paddr == OFS_SWEEP_COUNT) begin
        next_s.prdata = s.sweep_cnt;
      end else if (paddr == OFS_TIME_LO) begin
        next_s.prdata = s.time_cnt[31:0];
      end else if (paddr == OFS_TIME_HI) begin
        next_s.prdata = {10'h0, s.time_cnt[53:32]};
      end else if (paddr == OFS_START_COUNT) begin
        next_s.prdata = s.start_cnt;
      end else begin
        next_s.pslverr = 1'b1;
      end
    end

    // Status levels follow the phase being entered
    next_s.running = (next_s.phase == PH_DELAY) || (next_s.phase == PH_SWEEP);
    next_s.window = (next_s.phase == PH_SWEEP);
    next_s.pause = (next_s.phase == PH_HOLD);
    next_s.blank = (next_s.phase == PH_EOS);

    // Sync source map: inputs, status, fixed frequencies, counter bits
    src[5:0] = {stop_inputs, start_in};
    src[9:6] = {s.blank, s.pause, s.window, s.running};
    src[15:10] = freq_taps;
    src[47:16] = s.time_cnt[31:0];
    src[59:48] = s.sweep_cnt[11:0];
    sel1 = s.sync_cfg[SEL_W-1:0];
    sel2 = s.sync_cfg[SYNC2_LSB+:SEL_W];
    next_s.fast_sync = src[sel1] ^ s.sync_cfg[SEL_W];
    // The slow output cannot carry the fastest tones; it parks at idle level
    if (sel2 >= SRC_FREQ_FAST && sel2 <= SRC_FREQ_END) begin
      next_s.slow_sync = s.sync_cfg[SYNC2_LSB+SEL_W];
    end else begin
      next_s.slow_sync = src[sel2] ^ s.sync_cfg[SYNC2_LSB+SEL_W];
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state flops
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign fast_sync_output = s.fast_sync;
  assign slow_sync_output = s.slow_sync;
  assign sweep_running = s.running;
  assign measure_window = s.window;
  assign trigger_pause_window = s.pause;
  assign end_of_sweep_blank = s.blank;
  assign acq_running = s.acquiring;
  assign evt = s.evt;

endmodule // tdc_sweep_timing_control
